// File: src/fvc_consts.svh
// constants for the frequency/voltage change control block
// Overview of operation
// - no frequency or voltage capability: fault every access
// - control survives warm reset, cold reset clears it
// - bits 51-32 hold stop-grant wait, 5ns units
// - changes move to the stored target codes
// - writing 1 to bit 16 starts a change
// - initiate bit is write-only, reads as 0
// - only the bootstrap processor acts on initiate
// - initiate write issues the frequency-change bus cycle
// - target voltage in bits 13-8, clamped to limit
// - target frequency in bits 5-0, clamped to limit
// - frequency code means 4x plus half the code
// - status shows present, startup, limit frequency codes
// - status shows voltage codes and pending bit 31
// - pending sets on initiate, clears when change done
// - status bit 56 shows voltage step size
`ifndef FVC_CONSTS_SVH
`define FVC_CONSTS_SVH

`define FVC_CTL_ADDR      32'hc0010041
`define FVC_STS_ADDR      32'hc0010042
`define FVC_CTL_RESET     64'h0000_0000_0000_0000
`define FVC_CODE_W        6
`define FVC_STP_W         20
`define FVC_STP_LSB       32
`define FVC_STP_MSB       51
`define FVC_INIT_BIT      16
`define FVC_VOLT_LSB      8
`define FVC_VOLT_MSB      13
`define FVC_FREQ_LSB      0
`define FVC_FREQ_MSB      5
`define FVC_PEND_BIT      31
`define FVC_STEP_BIT      56
`define FVC_WAIT_W        18
`define FVC_SYS_CYCLE_PS  5000
`define FVC_CLK_PERIOD_PS 40000
`define FVC_SYS_PER_CLK   (`FVC_CLK_PERIOD_PS / `FVC_SYS_CYCLE_PS)
`define FVC_STRAP_LOAD    2'h2
`define FVC_STRAP_DONE    2'h3

`endif

// File: src/fvc_pkg.sv
// types shared by the frequency/voltage change control block
`include "fvc_consts.svh"

package fvc_pkg;

	typedef logic [`FVC_CODE_W-1:0] code_t;

	typedef enum logic [0:0] {
		ST_IDLE   = 1'b0,
		ST_SETTLE = 1'b1
	} fsm_t;

	typedef struct packed {
		code_t      startup_freq;
		code_t      freq_limit;
		code_t      startup_volt;
		code_t      volt_limit;
		code_t      ramp_volt;
		logic       step_size;
		logic [2:0] alt_offset;
		logic       intermediate;
	} strap_t;

	typedef struct packed {
		logic [`FVC_WAIT_W-1:0] cnt;
		logic                   done;
	} timer_state_t;

	typedef struct packed {
		code_t                 tgt_freq;
		code_t                 tgt_volt;
		logic [`FVC_STP_W-1:0] stp_cnt;
		strap_t                strap_s1;
		strap_t                strap_s2;
		logic [1:0]            init_cnt;
		code_t                 present_freq;
		code_t                 present_volt;
		code_t                 apply_freq;
		code_t                 apply_volt;
		fsm_t                  state;
		logic                  pending;
		logic                  bus_cycle;
		logic                  ack;
		logic                  gp;
		logic [63:0]           rdata;
	} fvc_state_t;

endpackage : fvc_pkg

// File: src/fvc_settle_timer.sv
// down-counter that times the settle wait after a new frequency code
`timescale 1ns/1ps
`default_nettype none
`include "fvc_consts.svh"

module fvc_settle_timer
	import fvc_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   rstn_i,
	input  wire logic                   load_i,
	input  wire logic                   abort_i,
	input  wire logic [`FVC_WAIT_W-1:0] cycles_i,
	output logic                        done_o
);
	timer_state_t st_reg;
	timer_state_t st_next;

	always_comb begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		if (abort_i) begin
			st_next.cnt = '0;
		end else if (load_i) begin
			st_next.cnt = cycles_i;
		end else if (st_reg.cnt != '0) begin
			st_next.cnt  = st_reg.cnt - 1'b1;
			st_next.done = (st_reg.cnt == `FVC_WAIT_W'(1));
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign done_o = st_reg.done;

endmodule : fvc_settle_timer

`default_nettype wire

// File: src/freq_voltage_change_ctl.sv
// frequency/voltage change control and status registers
`timescale 1ns/1ps
`default_nettype none
`include "fvc_consts.svh"

module freq_voltage_change_ctl
	import fvc_pkg::*;
(
	input  wire logic          clk_i,
	input  wire logic          rstn_i,
	input  wire logic          warm_reset_i,
	input  wire logic          freq_ctl_cap_i,
	input  wire logic          volt_ctl_cap_i,
	input  wire logic          is_bsp_i,
	input  wire logic          msr_rd_i,
	input  wire logic          msr_wr_i,
	input  wire logic [31:0]   msr_addr_i,
	input  wire logic [63:0]   msr_wdata_i,
	input  wire fvc_pkg::code_t startup_freq_code_i,
	input  wire fvc_pkg::code_t freq_code_limit_i,
	input  wire fvc_pkg::code_t startup_voltage_code_i,
	input  wire fvc_pkg::code_t voltage_code_limit_i,
	input  wire fvc_pkg::code_t ramp_voltage_limit_i,
	input  wire logic          voltage_step_size_i,
	input  wire logic [2:0]    alternate_voltage_offset_i,
	input  wire logic          intermediate_state_support_i,
	output logic               msr_ack_o,
	output logic [63:0]        msr_rdata_o,
	output logic               general_protection_fault_o,
	output logic               freq_change_cycle_o,
	output logic               change_pending_o,
	output fvc_pkg::code_t     pll_freq_code_o,
	output fvc_pkg::code_t     vreg_voltage_code_o
);
	import fvc_pkg::*;

	fvc_state_t st_reg;
	fvc_state_t st_next;

	logic                   hit_ctl;
	logic                   hit_sts;
	logic                   cap_ok;
	logic                   ctl_wr;
	logic                   start;
	logic                   timer_done;
	logic [`FVC_WAIT_W-1:0] wait_cycles;
	logic [`FVC_STP_W:0]    wait_sum;
	code_t                  wr_freq;
	code_t                  wr_volt;
	strap_t                 strap_in;

	assign strap_in = '{
		startup_freq: startup_freq_code_i,
		freq_limit:   freq_code_limit_i,
		startup_volt: startup_voltage_code_i,
		volt_limit:   voltage_code_limit_i,
		ramp_volt:    ramp_voltage_limit_i,
		step_size:    voltage_step_size_i,
		alt_offset:   alternate_voltage_offset_i,
		intermediate: intermediate_state_support_i
	};

	assign hit_ctl = (msr_addr_i == `FVC_CTL_ADDR);
	assign hit_sts = (msr_addr_i == `FVC_STS_ADDR);
	assign cap_ok  = freq_ctl_cap_i | volt_ctl_cap_i;
	assign ctl_wr  = msr_wr_i & hit_ctl & cap_ok;
	// a non-bootstrap core never sees the initiate bit set
	assign start   = ctl_wr & msr_wdata_i[`FVC_INIT_BIT] & is_bsp_i & ~warm_reset_i;

	// lower voltage code means higher voltage, so the clamp is a floor on the code
	always_comb begin
		wr_freq = msr_wdata_i[`FVC_FREQ_MSB:`FVC_FREQ_LSB];
		wr_volt = msr_wdata_i[`FVC_VOLT_MSB:`FVC_VOLT_LSB];
		if (wr_freq > st_reg.strap_s2.freq_limit) begin
			wr_freq = st_reg.strap_s2.freq_limit;
		end
		if (wr_volt < st_reg.strap_s2.volt_limit) begin
			wr_volt = st_reg.strap_s2.volt_limit;
		end
	end

	// stop-grant count is in 5 ns units; round the wait up to whole clocks, never below one
	always_comb begin
		wait_sum    = {1'b0, msr_wdata_i[`FVC_STP_MSB:`FVC_STP_LSB]} + (`FVC_STP_W+1)'(`FVC_SYS_PER_CLK - 1);
		wait_cycles = `FVC_WAIT_W'(wait_sum / (`FVC_STP_W+1)'(`FVC_SYS_PER_CLK));
		if (wait_cycles == '0) begin
			wait_cycles = `FVC_WAIT_W'(1);
		end
	end

	always_comb begin
		st_next           = st_reg;
		st_next.strap_s1  = strap_in;
		st_next.strap_s2  = st_reg.strap_s1;
		st_next.ack       = 1'b0;
		st_next.gp        = 1'b0;
		st_next.bus_cycle = 1'b0;
		st_next.rdata     = '0;

		// startup codes become the present codes once the straps are through the synchroniser
		if (st_reg.init_cnt != `FVC_STRAP_DONE) begin
			st_next.init_cnt = st_reg.init_cnt + 2'h1;
		end
		if (st_reg.init_cnt == `FVC_STRAP_LOAD) begin
			st_next.present_freq = st_reg.strap_s2.startup_freq;
			st_next.present_volt = st_reg.strap_s2.startup_volt;
		end

		// other addresses belong to other register blocks and get no answer here
		if ((msr_rd_i | msr_wr_i) & (hit_ctl | hit_sts)) begin
			if (!cap_ok) begin
				st_next.gp = 1'b1;
			end else begin
				st_next.ack = 1'b1;
				if (msr_rd_i & hit_ctl) begin
					st_next.rdata = {12'h000, st_reg.stp_cnt, 15'h0000, 1'b0,
						2'b00, st_reg.tgt_volt, 2'b00, st_reg.tgt_freq};
				end else if (msr_rd_i & hit_sts) begin
					st_next.rdata = {2'b00, st_reg.strap_s2.intermediate, 1'b0, st_reg.strap_s2.alt_offset,
						st_reg.strap_s2.step_size, 2'b00, st_reg.strap_s2.volt_limit,
						2'b00, st_reg.strap_s2.startup_volt, 2'b00, st_reg.present_volt,
						st_reg.pending, 1'b0, st_reg.strap_s2.ramp_volt, 2'b00, st_reg.strap_s2.freq_limit,
						2'b00, st_reg.strap_s2.startup_freq, 2'b00, st_reg.present_freq};
				end
			end
		end

		if (ctl_wr) begin
			st_next.tgt_freq = wr_freq;
			st_next.tgt_volt = wr_volt;
			st_next.stp_cnt  = msr_wdata_i[`FVC_STP_MSB:`FVC_STP_LSB];
		end

		// warm reset aborts a change in flight but leaves the control fields alone
		if (warm_reset_i) begin
			st_next.state   = ST_IDLE;
			st_next.pending = 1'b0;
		end else begin
			case (st_reg.state)
				ST_IDLE: begin
					st_next.state = ST_IDLE;
				end
				ST_SETTLE: begin
					if (timer_done) begin
						st_next.present_freq = st_reg.apply_freq;
						st_next.present_volt = st_reg.apply_volt;
						st_next.pending      = 1'b0;
						st_next.state        = ST_IDLE;
					end
				end
				default: begin
					st_next.state = ST_IDLE;
				end
			endcase
		end

		// a new initiate restarts the wait, so set wins over the completion clear
		if (start) begin
			st_next.apply_freq = wr_freq;
			st_next.apply_volt = wr_volt;
			st_next.bus_cycle  = 1'b1;
			st_next.pending    = 1'b1;
			st_next.state      = ST_SETTLE;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg       <= '0;
			st_reg.state <= ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	fvc_settle_timer u_settle_timer (
		.clk_i    (clk_i),
		.rstn_i   (rstn_i),
		.load_i   (start),
		.abort_i  (warm_reset_i),
		.cycles_i (wait_cycles),
		.done_o   (timer_done)
	);

	assign msr_ack_o                  = st_reg.ack;
	assign msr_rdata_o                = st_reg.rdata;
	assign general_protection_fault_o = st_reg.gp;
	assign freq_change_cycle_o        = st_reg.bus_cycle;
	assign change_pending_o           = st_reg.pending;
	assign pll_freq_code_o            = st_reg.apply_freq;
	assign vreg_voltage_code_o        = st_reg.apply_volt;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_change_begins;
		start ##1 (change_pending_o && freq_change_cycle_o);
	endsequence

	// a second initiate right behind the first legally raises the bus cycle again
	sequence s_cycle_single;
		!freq_change_cycle_o || $past(start);
	endsequence

	a_no_cap_fault: assert property ((msr_rd_i || msr_wr_i) && (hit_ctl || hit_sts) && !cap_ok
		|=> general_protection_fault_o && !msr_ack_o)
		else $error("access without capability not faulted");

	a_warm_keeps_ctl: assert property (warm_reset_i && !ctl_wr
		|=> $stable(st_reg.tgt_freq) && $stable(st_reg.tgt_volt) && $stable(st_reg.stp_cnt))
		else $error("warm reset disturbed control fields");

	a_init_reads_zero: assert property (msr_ack_o |-> !msr_rdata_o[`FVC_INIT_BIT])
		else $error("initiate bit read back as one");

	a_non_bsp_quiet: assert property (ctl_wr && !is_bsp_i |=> !freq_change_cycle_o)
		else $error("non-bootstrap core started a change");

	a_change_start: assert property (start |-> s_change_begins ##1 s_cycle_single)
		else $error("initiate did not pulse bus cycle and set pending");

	a_freq_clamp: assert property (ctl_wr
		&& msr_wdata_i[`FVC_FREQ_MSB:`FVC_FREQ_LSB] > st_reg.strap_s2.freq_limit
		|=> st_reg.tgt_freq == $past(st_reg.strap_s2.freq_limit))
		else $error("frequency target not clamped");

	a_volt_clamp: assert property (ctl_wr
		&& msr_wdata_i[`FVC_VOLT_MSB:`FVC_VOLT_LSB] < st_reg.strap_s2.volt_limit
		|=> st_reg.tgt_volt == $past(st_reg.strap_s2.volt_limit))
		else $error("voltage target not clamped");

	a_settle_done: assert property (timer_done && !start && !warm_reset_i
		|=> !change_pending_o && st_reg.present_freq == pll_freq_code_o)
		else $error("change completion did not update status");

	a_min_wait: assert property (start ##1 (!start && !warm_reset_i) |=> change_pending_o)
		else $error("pending dropped before settle wait");

	a_pending_state: assert property (change_pending_o |-> st_reg.state == ST_SETTLE)
		else $error("pending without a change in flight");

	a_rdata_idle: assert property (!msr_ack_o |-> msr_rdata_o == '0)
		else $error("read data not zero outside an answer");

	a_ack_or_fault: assert property (!(msr_ack_o && general_protection_fault_o))
		else $error("access both answered and faulted");

	a_ack_follows: assert property ((msr_rd_i || msr_wr_i) && (hit_ctl || hit_sts) && cap_ok
		|=> msr_ack_o && !general_protection_fault_o)
		else $error("permitted access not answered");

	a_unmapped_quiet: assert property ((msr_rd_i || msr_wr_i) && !hit_ctl && !hit_sts
		|=> !msr_ack_o && !general_protection_fault_o)
		else $error("foreign address answered");

	a_fault_keeps_ctl: assert property (msr_wr_i && hit_ctl && !cap_ok
		|=> $stable(st_reg.tgt_freq) && $stable(st_reg.tgt_volt) && $stable(st_reg.stp_cnt))
		else $error("refused write changed control fields");

	a_fault_no_change: assert property (msr_wr_i && hit_ctl && !cap_ok |=> !freq_change_cycle_o)
		else $error("refused write started a change");

	a_ctl_readback: assert property (msr_rd_i && hit_ctl && cap_ok
		|=> msr_ack_o && msr_rdata_o[`FVC_STP_MSB:`FVC_STP_LSB] == $past(st_reg.stp_cnt))
		else $error("stop-grant count not read back");

	a_pending_bit: assert property (msr_rd_i && hit_sts && cap_ok
		|=> msr_rdata_o[`FVC_PEND_BIT] == $past(change_pending_o))
		else $error("status pending bit wrong");

	a_step_bit: assert property (msr_rd_i && hit_sts && cap_ok
		|=> msr_rdata_o[`FVC_STEP_BIT] == $past(st_reg.strap_s2.step_size))
		else $error("status step bit wrong");

	a_present_field: assert property (msr_rd_i && hit_sts && cap_ok
		|=> msr_rdata_o[`FVC_FREQ_MSB:`FVC_FREQ_LSB] == $past(st_reg.present_freq))
		else $error("status present frequency wrong");

	a_warm_abort: assert property (warm_reset_i |=> !change_pending_o && !freq_change_cycle_o)
		else $error("warm reset left a change running");

	a_apply_target: assert property (start
		|=> pll_freq_code_o == st_reg.tgt_freq && vreg_voltage_code_o == st_reg.tgt_volt)
		else $error("applied codes differ from stored targets");

	a_pll_hold: assert property (!start |=> $stable(pll_freq_code_o) && $stable(vreg_voltage_code_o))
		else $error("applied codes moved without a change");

	a_present_hold: assert property (!timer_done && st_reg.init_cnt == `FVC_STRAP_DONE
		|=> $stable(st_reg.present_freq) && $stable(st_reg.present_volt))
		else $error("present codes moved without completion");

	a_freq_in_limit: assert property (freq_change_cycle_o
		|-> pll_freq_code_o <= $past(st_reg.strap_s2.freq_limit))
		else $error("applied frequency above limit");

	a_volt_in_limit: assert property (freq_change_cycle_o
		|-> vreg_voltage_code_o >= $past(st_reg.strap_s2.volt_limit))
		else $error("applied voltage code beyond limit");

endmodule : freq_voltage_change_ctl

`default_nettype wire

// File: verification/fvc_far_side.sv
// far-side model: strap source for the block and counter of change bus cycles
`timescale 1ns/1ps
`default_nettype none

module fvc_far_side
	import fvc_pkg::*;
#(
	parameter fvc_pkg::code_t SF = 6'h08,
	parameter fvc_pkg::code_t FL = 6'h20,
	parameter fvc_pkg::code_t SV = 6'h12,
	parameter fvc_pkg::code_t VL = 6'h0a,
	parameter fvc_pkg::code_t RP = 6'h04
)
(
	input  wire logic           clk_i,
	input  wire logic           rstn_i,
	input  wire logic           cycle_i,
	output fvc_pkg::code_t      sfreq_o,
	output fvc_pkg::code_t      flim_o,
	output fvc_pkg::code_t      svolt_o,
	output fvc_pkg::code_t      vlim_o,
	output fvc_pkg::code_t      ramp_o,
	output logic [7:0]          cycles_o
);
	// straps stay fixed: the block only samples them through its synchroniser
	assign sfreq_o = SF;
	assign flim_o  = FL;
	assign svolt_o = SV;
	assign vlim_o  = VL;
	assign ramp_o  = RP;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) cycles_o <= 8'h00;
		else if (cycle_i) cycles_o <= cycles_o + 8'h01;
	end
endmodule : fvc_far_side

`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the frequency/voltage change control block
`timescale 1ns/1ps
`default_nettype none
`include "fvc_consts.svh"

module tb;
	import fvc_pkg::*;
	localparam code_t SF = 6'h08, FL = 6'h20, SV = 6'h12, VL = 6'h0a, RP = 6'h04;
	logic clk_i = 1'b0, rstn_i = 1'b0, warm_reset_i = 1'b0, is_bsp_i = 1'b1;
	logic freq_ctl_cap_i = 1'b1, volt_ctl_cap_i = 1'b1, msr_rd_i = 1'b0, msr_wr_i = 1'b0;
	logic [31:0] msr_addr_i = 32'h0;
	logic [63:0] msr_wdata_i = 64'h0;
	code_t startup_freq_code_i, freq_code_limit_i, startup_voltage_code_i, voltage_code_limit_i;
	code_t ramp_voltage_limit_i, pll_freq_code_o, vreg_voltage_code_o, tf, tv;
	logic voltage_step_size_i = 1'b1, intermediate_state_support_i = 1'b1;
	logic [2:0] alternate_voltage_offset_i = 3'h5;
	logic msr_ack_o, general_protection_fault_o, freq_change_cycle_o, change_pending_o;
	logic [63:0] msr_rdata_o;
	logic [7:0] ncyc;
	logic [19:0] stp;
	logic [64:0] rq[$];
	logic [12:0] cq[$];
	int errors = 0, total_checks = 0;
	integer seed = 32'h3c44;

	freq_voltage_change_ctl u_dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .warm_reset_i(warm_reset_i), .freq_ctl_cap_i(freq_ctl_cap_i),
		.volt_ctl_cap_i(volt_ctl_cap_i), .is_bsp_i(is_bsp_i), .msr_rd_i(msr_rd_i), .msr_wr_i(msr_wr_i),
		.msr_addr_i(msr_addr_i), .msr_wdata_i(msr_wdata_i), .startup_freq_code_i(startup_freq_code_i),
		.freq_code_limit_i(freq_code_limit_i), .startup_voltage_code_i(startup_voltage_code_i),
		.voltage_code_limit_i(voltage_code_limit_i), .ramp_voltage_limit_i(ramp_voltage_limit_i),
		.voltage_step_size_i(voltage_step_size_i), .alternate_voltage_offset_i(alternate_voltage_offset_i),
		.intermediate_state_support_i(intermediate_state_support_i), .msr_ack_o(msr_ack_o),
		.msr_rdata_o(msr_rdata_o), .general_protection_fault_o(general_protection_fault_o),
		.freq_change_cycle_o(freq_change_cycle_o), .change_pending_o(change_pending_o),
		.pll_freq_code_o(pll_freq_code_o), .vreg_voltage_code_o(vreg_voltage_code_o));
	fvc_far_side #(.SF(SF), .FL(FL), .SV(SV), .VL(VL), .RP(RP)) u_far (
		.clk_i(clk_i), .rstn_i(rstn_i), .cycle_i(freq_change_cycle_o), .sfreq_o(startup_freq_code_i),
		.flim_o(freq_code_limit_i), .svolt_o(startup_voltage_code_i), .vlim_o(voltage_code_limit_i),
		.ramp_o(ramp_voltage_limit_i), .cycles_o(ncyc));

	always #20 clk_i = ~clk_i;

	function automatic logic [63:0] sts(code_t f, code_t v, logic p);
		return {3'h1, 1'b0, 3'h5, 1'b1, 2'b0, VL, 2'b0, SV, 2'b0, v, p, 1'b0, RP, 2'b0, FL, 2'b0, SF, 2'b0, f};
	endfunction : sts

	function automatic logic [63:0] ctl(logic [19:0] s, code_t f, code_t v, logic i);
		return {12'h0, s, 15'h0, i, 2'b0, v, 2'b0, f};
	endfunction : ctl

	task automatic chk_reg(input logic [64:0] g, input logic [64:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t reg got %h exp %h", $time, g, e);
		end
	endtask : chk_reg

	task automatic chk_chg(input logic [12:0] g, input logic [12:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t change got %h exp %h", $time, g, e);
		end
	endtask : chk_chg

	// one access per two cycles, so a strobe is never lowered and raised in one step
	task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d);
		msr_wr_i = w;
		msr_rd_i = !w;
		msr_addr_i = a;
		msr_wdata_i = d;
		@(posedge clk_i);
		#1;
		msr_wr_i = 1'b0;
		msr_rd_i = 1'b0;
		@(posedge clk_i);
		#1;
	endtask : acc

	task automatic rd(input logic [31:0] a, input logic [63:0] e);
		rq.push_back({1'b0, e});
		acc(1'b0, a, 64'h0);
	endtask : rd

	task automatic wrc(input logic [63:0] d);
		rq.push_back(65'h0);
		acc(1'b1, `FVC_CTL_ADDR, d);
	endtask : wrc

	task automatic pause(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : pause

	// an answer with no note pending is compared against unknown and so always fails
	always @(posedge clk_i) begin
		#2;
		if (msr_ack_o === 1'b1 || general_protection_fault_o === 1'b1)
			chk_reg({general_protection_fault_o, msr_rdata_o}, rq.size() ? rq.pop_front() : 65'bx);
		if (freq_change_cycle_o === 1'b1)
			chk_chg({change_pending_o, pll_freq_code_o, vreg_voltage_code_o}, cq.size() ? cq.pop_front() : 13'bx);
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		#100000;
		errors++;
		wrap_up();
	end

	initial begin
		pause(20);
		rstn_i = 1'b1;
		pause(4);
		rd(`FVC_CTL_ADDR, 64'h0);
		rd(`FVC_STS_ADDR, sts(SF, SV, 1'b0));
		$display("test reset done");
		repeat (4) begin
			tf = code_t'($random(seed)) & 6'h1e;
			tv = VL + (code_t'($random(seed)) & 6'h1f);
			stp = 20'($random(seed));
			wrc(ctl(stp, tf, tv, 1'b0));
			rd(`FVC_CTL_ADDR, ctl(stp, tf, tv, 1'b0));
		end
		wrc(ctl(20'h0, 6'h2a, 6'h02, 1'b0));
		rd(`FVC_CTL_ADDR, ctl(20'h0, FL, VL, 1'b0));
		$display("test targets done");
		tf = 6'h10;
		tv = 6'h0c;
		cq.push_back({1'b1, tf, tv});
		wrc(ctl(20'h320, tf, tv, 1'b1));
		rd(`FVC_STS_ADDR, sts(SF, SV, 1'b1));
		rd(`FVC_CTL_ADDR, ctl(20'h320, tf, tv, 1'b0));
		pause(110);
		rd(`FVC_STS_ADDR, sts(tf, tv, 1'b0));
		cq.push_back({1'b1, FL, VL});
		wrc(ctl(20'h0, 6'h2a, 6'h00, 1'b1));
		pause(10);
		rd(`FVC_STS_ADDR, sts(FL, VL, 1'b0));
		$display("test change done");
		is_bsp_i = 1'b0;
		wrc(ctl(20'h0, 6'h04, 6'h20, 1'b1));
		pause(10);
		is_bsp_i = 1'b1;
		rd(`FVC_STS_ADDR, sts(FL, VL, 1'b0));
		warm_reset_i = 1'b1;
		pause(1);
		warm_reset_i = 1'b0;
		rd(`FVC_CTL_ADDR, ctl(20'h0, 6'h04, 6'h20, 1'b0));
		// warm reset in the middle of a long settle wait must abort it and keep the present codes
		cq.push_back({1'b1, 6'h06, 6'h14});
		wrc(ctl(20'h320, 6'h06, 6'h14, 1'b1));
		warm_reset_i = 1'b1;
		pause(1);
		warm_reset_i = 1'b0;
		rd(`FVC_STS_ADDR, sts(FL, VL, 1'b0));
		rd(`FVC_CTL_ADDR, ctl(20'h320, 6'h06, 6'h14, 1'b0));
		chk_chg({5'h0, ncyc}, 13'h003);
		rstn_i = 1'b0;
		pause(1);
		rstn_i = 1'b1;
		pause(4);
		rd(`FVC_CTL_ADDR, 64'h0);
		$display("test resets done");
		acc(1'b0, 32'hc0010043, 64'h0);
		acc(1'b1, 32'hc0010040, 64'h1_0000);
		for (int c = 0; c < 4; c++) begin
			{freq_ctl_cap_i, volt_ctl_cap_i} = 2'(c);
			rq.push_back({c == 0, 64'h0});
			acc(1'b1, `FVC_CTL_ADDR, ctl(20'h0, 6'h08, 6'h10, c == 0));
			// with no capability the status read faults as well
			rq.push_back({c == 0, c == 0 ? 64'h0 : sts(SF, SV, 1'b0)});
			acc(1'b0, `FVC_STS_ADDR, 64'h0);
		end
		rd(`FVC_CTL_ADDR, ctl(20'h0, 6'h08, 6'h10, 1'b0));
		$display("test access done");
		chk_chg({5'h0, ncyc}, 13'h000);
		wrap_up();
	end
endmodule : tb

`default_nettype wire
